/* include/aic_pkg.sv */
/*
  constants, register map and types for the four-channel current input formatter.
  assumes a 200 MHz system clock and a converter that reports loop current in microamps.
*/
`default_nettype none
package aic_pkg;
  localparam int NUM_CH = 4;
  localparam int CLK_MHZ = 200;
  localparam int ROUND_MS = 80;
  localparam int SEND_US = 6500;
  localparam int ROUND_CYC = ROUND_MS * 1000 * CLK_MHZ;
  localparam int SEND_CYC = SEND_US * CLK_MHZ;
  localparam int FIELD_COMM_DIV = 3;
  localparam int PCT_FULL = 10000;
  localparam int PCT_MIN = -2500;
  localparam int PCT_MAX = 12500;
  localparam int RATE_DIV = 100000;
  localparam int OUT_OCTETS_EIGHT = 8;

  // per-channel block: address bits [4:3] pick the channel, [2:0] the register
  localparam logic [2:0] OFS_CFG = 3'h0;
  localparam logic [2:0] OFS_RATE = 3'h1;
  localparam logic [2:0] OFS_SIM = 3'h2;
  localparam logic [2:0] OFS_FALLBACK = 3'h3;
  localparam logic [2:0] OFS_OPEN_THR = 3'h4;
  localparam logic [2:0] OFS_SHORT_THR = 3'h5;
  localparam logic [2:0] OFS_SCALE_START = 3'h6;
  localparam logic [2:0] OFS_SCALE_END = 3'h7;
  localparam logic [5:0] ADDR_CTRL = 6'h20;
  localparam logic [5:0] ADDR_STATUS = 6'h21;
  localparam logic [5:0] ADDR_WORD_BASE = 6'h28;

  localparam int CFG_SIM_BIT = 0;
  localparam int CFG_SIMINV_BIT = 1;
  localparam int CFG_ERR_LSB = 2;
  localparam int CFG_LFD_BIT = 4;
  localparam int CTRL_WORD_BIT = 0;
  localparam int CTRL_LAYOUT_BIT = 1;

  localparam logic [4:0] RST_CFG = 5'h10;
  localparam logic [15:0] RST_RATE = 16'h0000;
  localparam logic [15:0] RST_PCT = 16'h0000;
  localparam logic [15:0] RST_OPEN_UA = 16'h03e8;
  localparam logic [15:0] RST_SHORT_UA = 16'h5208;
  localparam logic [15:0] RST_SCALE_START = 16'h2710;
  localparam logic [15:0] RST_SCALE_END = 16'hc350;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [15:0] SCALE_MIN = 16'h2710;
  localparam logic [15:0] SCALE_MAX = 16'hc350;
  localparam logic [15:0] LIVE_ZERO_UA = 16'h0e10;
  localparam logic [15:0] I_ZERO_UA = 16'h0fa0;
  localparam int I_SPAN_UA = 16000;

  typedef enum logic [1:0] {
    ERR_CURRENT = 2'b00,
    ERR_FALLBACK = 2'b01,
    ERR_HOLD = 2'b10
  } err_mode_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_state_t;
endpackage : aic_pkg
`default_nettype wire

/* rtl/analog_input_channel_formatter.sv */
/*
  four-channel current input formatter: scaling, rate limiting, simulation and
  error substitution, status packing and cyclic octet stream to the com unit.
  assumes the converter and com unit run on ref_clk_in; the field comm pin is asynchronous.
*/
// What this block does
// - rate limit per round; zero rate disables
// - simulation sends clamped percent value
// - flag marks simulation value invalid
// - on error send clamped fallback percent
// - fallback value always marked invalid
// - four channel conversion round every 80 ms
// - send channel words every 6.5 ms
// - field comm: refresh every third cycle
// - word order high first, else ascending
// - values are unsigned 0 to 65535
// - twelve value bits, four status bits
// - no status bits outside scaling window
// - channels sent in ascending order
// - bit0 flags current below 3.6 mA
// - bit1 line fault, bits 2-3 zero
// - layout selects zero or eight output octets
// - line fault detection enabled per channel
// - open below low, short above high
// - normal sends live, simulation sends simulated
// - error mode: current, fallback or hold
// - line fault reported and triggers handling
`timescale 1ns/1ps
`default_nettype none
module analog_input_channel_formatter #(
  parameter int ROUND_CYCLES = aic_pkg::ROUND_CYC,
  parameter int SEND_CYCLES = aic_pkg::SEND_CYC
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [5:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rd_data_out,
  // converter
  output logic conv_start_out,
  input wire logic conv_valid_in,
  input wire logic [1:0] conv_ch_in,
  input wire logic [15:0] conv_current_in,
  // field protocol activity pin
  input wire logic field_comm_active_in,
  // com unit stream
  output logic tx_valid_out,
  output logic tx_first_out,
  output logic [7:0] tx_data_out,
  output logic [3:0] tx_invalid_out,
  output logic [3:0] out_octets_out
);
  import aic_pkg::*;

  function automatic logic [15:0] clamp_u16(input logic signed [39:0] v);
    if (v < 40'sh0) begin
      return 16'h0000;
    end else if (v > 40'sh000000ffff) begin
      return 16'hffff;
    end
    return v[15:0];
  endfunction : clamp_u16

  function automatic logic [15:0] clamp_pct(input logic [15:0] v);
    logic signed [15:0] s;
    s = $signed(v);
    if (s < 16'(PCT_MIN)) begin
      return 16'(PCT_MIN);
    end else if (s > 16'(PCT_MAX)) begin
      return 16'(PCT_MAX);
    end
    return v;
  endfunction : clamp_pct

  function automatic logic signed [39:0] span_of(input logic [15:0] lo, input logic [15:0] hi);
    return $signed({24'h0, hi}) - $signed({24'h0, lo});
  endfunction : span_of

  function automatic logic [15:0] pct_to_pts(input logic [15:0] lo, input logic [15:0] hi,
                                             input logic [15:0] pct);
    logic signed [39:0] p;
    p = $signed({{24{pct[15]}}, pct});
    return clamp_u16($signed({24'h0, lo}) + span_of(lo, hi) * p / 40'(PCT_FULL));
  endfunction : pct_to_pts

  function automatic logic [15:0] cur_to_pts(input logic [15:0] lo, input logic [15:0] hi,
                                             input logic [15:0] cur);
    logic signed [39:0] d;
    d = $signed({24'h0, cur}) - $signed({24'h0, I_ZERO_UA});
    return clamp_u16($signed({24'h0, lo}) + span_of(lo, hi) * d / 40'(I_SPAN_UA));
  endfunction : cur_to_pts

  // configuration registers
  logic [4:0] cfg_r [NUM_CH];
  logic [15:0] rate_r [NUM_CH];
  logic [15:0] sim_r [NUM_CH];
  logic [15:0] fb_r [NUM_CH];
  logic [15:0] open_r [NUM_CH];
  logic [15:0] short_r [NUM_CH];
  logic [15:0] start_r [NUM_CH];
  logic [15:0] end_r [NUM_CH];
  logic [1:0] ctrl_r;
  // channel state
  logic [15:0] cur_r [NUM_CH];
  logic [15:0] filt_r [NUM_CH];
  logic [15:0] last_r [NUM_CH];
  logic [15:0] snap_r [NUM_CH];
  logic [NUM_CH-1:0] snap_inv_r;
  logic [NUM_CH-1:0] lf_r;
  // timing and stream
  logic [31:0] round_cnt_r;
  logic [31:0] send_cnt_r;
  logic [1:0] third_cnt_r;
  logic fc_s1_r;
  logic fc_s2_r;
  logic fc_s3_r;
  logic fc_r;
  tx_state_t tx_state_r;
  logic [2:0] tx_idx_r;

  wire ch_sel_w = (addr_in[5] == 1'b0);
  wire [1:0] acc_ch_w = addr_in[4:3];
  wire [2:0] acc_ofs_w = addr_in[2:0];
  wire round_tick_w = (round_cnt_r == 32'(ROUND_CYCLES - 1));
  wire send_tick_w = (send_cnt_r == 32'(SEND_CYCLES - 1));
  wire refresh_w = send_tick_w && (!fc_r || third_cnt_r == 2'(FIELD_COMM_DIV - 1));

  logic [15:0] word_w [NUM_CH];
  logic [15:0] sel_w [NUM_CH];
  logic [15:0] filt_nxt [NUM_CH];
  logic [NUM_CH-1:0] inv_w;
  logic [NUM_CH-1:0] err_w;
  logic [NUM_CH-1:0] lz_w;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      wire lfd_en_w = cfg_r[g][CFG_LFD_BIT];
      wire open_w = lfd_en_w && (cur_r[g] < open_r[g]);
      wire short_w = lfd_en_w && (cur_r[g] > short_r[g]);
      wire [15:0] raw_w = cur_to_pts(start_r[g], end_r[g], cur_r[g]);
      wire [15:0] simv_w = pct_to_pts(start_r[g], end_r[g], sim_r[g]);
      wire [15:0] fbv_w = pct_to_pts(start_r[g], end_r[g], fb_r[g]);
      wire signed [39:0] step_w = $signed({24'h0, rate_r[g]}) * span_of(start_r[g], end_r[g])
                                  * 40'(ROUND_MS) / 40'(RATE_DIV);
      wire signed [39:0] diff_w = $signed({24'h0, raw_w}) - $signed({24'h0, filt_r[g]});
      wire signed [39:0] up_w = $signed({24'h0, filt_r[g]}) + step_w;
      wire signed [39:0] dn_w = $signed({24'h0, filt_r[g]}) - step_w;
      wire err_mode_t mode_w = err_mode_t'(cfg_r[g][CFG_ERR_LSB +: 2]);
      wire status_on_w = (start_r[g] >= SCALE_MIN) && (end_r[g] <= SCALE_MAX);
      assign lz_w[g] = (cur_r[g] < LIVE_ZERO_UA);
      assign err_w[g] = open_w || short_w;
      // rate limiter: zero rate or a small step passes the raw value
      assign filt_nxt[g] = (rate_r[g] == 16'h0000) ? raw_w :
                           (diff_w > step_w) ? clamp_u16(up_w) :
                           (diff_w < -step_w) ? clamp_u16(dn_w) : raw_w;
      assign sel_w[g] = cfg_r[g][CFG_SIM_BIT] ? simv_w :
                        !err_w[g] ? filt_r[g] :
                        (mode_w == ERR_FALLBACK) ? fbv_w :
                        (mode_w == ERR_HOLD) ? last_r[g] : filt_r[g];
      assign inv_w[g] = cfg_r[g][CFG_SIM_BIT] ? cfg_r[g][CFG_SIMINV_BIT] :
                        (err_w[g] && mode_w == ERR_FALLBACK);
      assign word_w[g] = status_on_w ? {sel_w[g][15:4], 2'b00, err_w[g], lz_w[g]} : sel_w[g];
    end
  endgenerate

  // register writes
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cfg_r[i] <= RST_CFG;
        rate_r[i] <= RST_RATE;
        sim_r[i] <= RST_PCT;
        fb_r[i] <= RST_PCT;
        open_r[i] <= RST_OPEN_UA;
        short_r[i] <= RST_SHORT_UA;
        start_r[i] <= RST_SCALE_START;
        end_r[i] <= RST_SCALE_END;
      end
      ctrl_r <= RST_CTRL;
    end else if (wr_in) begin
      if (ch_sel_w) begin
        case (acc_ofs_w)
          OFS_CFG: cfg_r[acc_ch_w] <= wr_data_in[4:0];
          OFS_RATE: rate_r[acc_ch_w] <= wr_data_in;
          OFS_SIM: sim_r[acc_ch_w] <= clamp_pct(wr_data_in);
          OFS_FALLBACK: fb_r[acc_ch_w] <= clamp_pct(wr_data_in);
          OFS_OPEN_THR: open_r[acc_ch_w] <= wr_data_in;
          OFS_SHORT_THR: short_r[acc_ch_w] <= wr_data_in;
          OFS_SCALE_START: start_r[acc_ch_w] <= wr_data_in;
          OFS_SCALE_END: end_r[acc_ch_w] <= wr_data_in;
          default: ;
        endcase
      end else if (addr_in == ADDR_CTRL) begin
        ctrl_r <= wr_data_in[1:0];
      end
    end
  end

  // register reads, answered in the next cycle
  wire [15:0] ch_rd_w = (acc_ofs_w == OFS_CFG) ? {11'h000, cfg_r[acc_ch_w]} :
                        (acc_ofs_w == OFS_RATE) ? rate_r[acc_ch_w] :
                        (acc_ofs_w == OFS_SIM) ? sim_r[acc_ch_w] :
                        (acc_ofs_w == OFS_FALLBACK) ? fb_r[acc_ch_w] :
                        (acc_ofs_w == OFS_OPEN_THR) ? open_r[acc_ch_w] :
                        (acc_ofs_w == OFS_SHORT_THR) ? short_r[acc_ch_w] :
                        (acc_ofs_w == OFS_SCALE_START) ? start_r[acc_ch_w] : end_r[acc_ch_w];
  wire word_hit_w = (addr_in[5:2] == ADDR_WORD_BASE[5:2]);
  wire [15:0] rd_w = ch_sel_w ? ch_rd_w :
                     (addr_in == ADDR_CTRL) ? {14'h0000, ctrl_r} :
                     (addr_in == ADDR_STATUS) ? {3'h0, fc_r, snap_inv_r, lf_r, lz_w} :
                     word_hit_w ? snap_r[addr_in[1:0]] : 16'h0000;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rd_data_out <= 16'h0000;
    end else begin
      rd_data_out <= rd_in ? rd_w : 16'h0000;
    end
  end

  // field comm pin synchroniser, change taken once stages two and three agree
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      fc_s1_r <= 1'b0;
      fc_s2_r <= 1'b0;
      fc_s3_r <= 1'b0;
      fc_r <= 1'b0;
    end else begin
      fc_s1_r <= field_comm_active_in;
      fc_s2_r <= fc_s1_r;
      fc_s3_r <= fc_s2_r;
      if (fc_s2_r == fc_s3_r) begin
        fc_r <= fc_s3_r;
      end
    end
  end

  // conversion round timer and converter results
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      round_cnt_r <= 32'h0000_0000;
      conv_start_out <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        cur_r[i] <= I_ZERO_UA;
        filt_r[i] <= RST_SCALE_START;
        last_r[i] <= RST_SCALE_START;
      end
      lf_r <= '0;
    end else begin
      round_cnt_r <= round_tick_w ? 32'h0000_0000 : round_cnt_r + 32'h0000_0001;
      conv_start_out <= round_tick_w;
      if (conv_valid_in) begin
        cur_r[conv_ch_in] <= conv_current_in;
      end
      if (round_tick_w) begin
        lf_r <= err_w;
        for (int i = 0; i < NUM_CH; i++) begin
          filt_r[i] <= filt_nxt[i];
          if (!err_w[i]) begin
            last_r[i] <= filt_r[i];
          end
        end
      end
    end
  end

  // send cycle timer and snapshot of channel words
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      send_cnt_r <= 32'h0000_0000;
      third_cnt_r <= 2'h0;
      snap_inv_r <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        snap_r[i] <= 16'h0000;
      end
    end else begin
      send_cnt_r <= send_tick_w ? 32'h0000_0000 : send_cnt_r + 32'h0000_0001;
      if (send_tick_w) begin
        third_cnt_r <= (!fc_r || third_cnt_r == 2'(FIELD_COMM_DIV - 1)) ? 2'h0 : third_cnt_r + 2'h1;
      end
      if (refresh_w) begin
        snap_inv_r <= inv_w;
        for (int i = 0; i < NUM_CH; i++) begin
          snap_r[i] <= word_w[i];
        end
      end
    end
  end

  // octet stream: channel 0 first, two octets per channel word
  wire [15:0] tx_word_w = snap_r[tx_idx_r[2:1]];
  wire hi_first_w = ctrl_r[CTRL_WORD_BIT];
  wire [7:0] tx_byte_w = (hi_first_w ^ tx_idx_r[0]) ? tx_word_w[15:8] : tx_word_w[7:0];

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tx_state_r <= TX_IDLE;
      tx_idx_r <= 3'h0;
      tx_valid_out <= 1'b0;
      tx_first_out <= 1'b0;
      tx_data_out <= 8'h00;
      tx_invalid_out <= 4'h0;
      out_octets_out <= 4'h0;
    end else begin
      out_octets_out <= ctrl_r[CTRL_LAYOUT_BIT] ? 4'(OUT_OCTETS_EIGHT) : 4'h0;
      case (tx_state_r)
        TX_IDLE: begin
          tx_valid_out <= 1'b0;
          tx_first_out <= 1'b0;
          if (send_tick_w) begin
            tx_state_r <= TX_SEND;
            tx_idx_r <= 3'h0;
          end
        end
        TX_SEND: begin
          tx_valid_out <= 1'b1;
          tx_first_out <= (tx_idx_r == 3'h0);
          tx_data_out <= tx_byte_w;
          tx_invalid_out <= snap_inv_r;
          tx_idx_r <= tx_idx_r + 3'h1;
          if (tx_idx_r == 3'h7) begin
            tx_state_r <= TX_IDLE;
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end
endmodule : analog_input_channel_formatter
`default_nettype wire

/* testbench/analog_input_channel_formatter_chk.sv */
/* port checker for the channel formatter.
   assumes it is bound to the top module with the same cycle parameters. */
`timescale 1ns/1ps
`default_nettype none
module analog_input_channel_formatter_chk
  import aic_pkg::*;
#(
  parameter int ROUND_CYCLES = 200,
  parameter int SEND_CYCLES = 40
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [5:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rd_data_out,
  // converter and stream
  input wire logic conv_start_out,
  input wire logic tx_valid_out,
  input wire logic tx_first_out,
  input wire logic [3:0] tx_invalid_out,
  input wire logic [3:0] out_octets_out
);
  logic [31:0] send_cnt_r;
  logic send_seen_r;
  logic [31:0] conv_cnt_r;
  logic conv_seen_r;
  // cycles since the last frame start and the last round start
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      send_cnt_r <= 32'h0;
      send_seen_r <= 1'b0;
      conv_cnt_r <= 32'h0;
      conv_seen_r <= 1'b0;
    end else begin
      send_cnt_r <= tx_first_out ? 32'h1 : send_cnt_r + 32'h1;
      send_seen_r <= send_seen_r | tx_first_out;
      conv_cnt_r <= conv_start_out ? 32'h1 : conv_cnt_r + 32'h1;
      conv_seen_r <= conv_seen_r | conv_start_out;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence frame_body_s;
    tx_valid_out [*8] ##1 !tx_valid_out;
  endsequence
  sequence later_octets_s;
    !tx_first_out [*7];
  endsequence
  property layout_p;
    logic lay;
    (wr_in && addr_in == ADDR_CTRL, lay = wr_data_in[CTRL_LAYOUT_BIT]) |-> ##2 out_octets_out == (lay ? 4'h8 : 4'h0);
  endproperty
  chk_frame_length: assert property ($rose(tx_valid_out) |-> frame_body_s) else $error("frame length wrong");
  chk_first_mark: assert property ($rose(tx_valid_out) |-> tx_first_out ##1 later_octets_s) else $error("first mark wrong");
  chk_first_valid: assert property (tx_first_out |-> tx_valid_out) else $error("first without valid");
  chk_send_period: assert property (tx_first_out && send_seen_r |-> send_cnt_r == SEND_CYCLES) else $error("send period");
  chk_round_period: assert property (conv_start_out && conv_seen_r |-> conv_cnt_r == ROUND_CYCLES) else $error("round period");
  chk_round_pulse: assert property (conv_start_out |=> !conv_start_out) else $error("round pulse long");
  chk_flags_steady: assert property (tx_valid_out && !tx_first_out |-> $stable(tx_invalid_out)) else $error("flags moved");
  chk_layout_octets: assert property (layout_p) else $error("output octet count");
  chk_read_idle: assert property (!rd_in |=> rd_data_out == 16'h0) else $error("read data not idle");
  chk_read_hole: assert property (rd_in && addr_in inside {[6'h22:6'h27]} |=> rd_data_out == 16'h0) else $error("hole read");
endmodule : analog_input_channel_formatter_chk
`default_nettype wire

/* testbench/com_unit_model.sv */
/* com unit collector: gathers the eight octets of each send cycle.
   assumes octets arrive on consecutive cycles, the first one marked. */
`timescale 1ns/1ps
`default_nettype none
module com_unit_model (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // octet stream
  input wire logic tx_valid_in,
  input wire logic tx_first_in,
  input wire logic [7:0] tx_data_in,
  // collected frame, octet k at bits 8k
  output logic [63:0] frame_out,
  output logic frame_done_out
);
  logic [2:0] idx_r;
  logic [63:0] buf_r;
  wire [2:0] idx_nxt = tx_first_in ? 3'h0 : idx_r;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      idx_r <= 3'h0;
      buf_r <= 64'h0;
      frame_out <= 64'h0;
      frame_done_out <= 1'b0;
    end else begin
      frame_done_out <= tx_valid_in && idx_nxt == 3'h7;
      if (tx_valid_in) begin
        buf_r[idx_nxt*8 +: 8] <= tx_data_in;
        idx_r <= idx_nxt + 3'h1;
        if (idx_nxt == 3'h7) frame_out <= {tx_data_in, buf_r[55:0]};
      end
    end
  end
endmodule : com_unit_model
`default_nettype wire

/* testbench/analog_input_channel_formatter_tb.sv */
/* self-checking bench for the channel formatter with a com unit collector.
   assumes short round and send counts so the run stays brief. */
`timescale 1ns/1ps
`default_nettype none
module analog_input_channel_formatter_tb;
  import aic_pkg::*;
  localparam int RC = 200;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [5:0] addr_in = 6'h00;
  logic [15:0] wr_data_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic conv_valid_in = 1'b0;
  logic [1:0] conv_ch_in = 2'h0;
  logic [15:0] conv_current_in = 16'h0000;
  logic field_comm_active_in = 1'b0;
  logic [15:0] rd_data_out;
  logic conv_start_out, tx_valid_out, tx_first_out, done;
  logic [7:0] tx_data_out;
  logic [3:0] tx_invalid_out, out_octets_out;
  logic [63:0] frame;
  int n_fail = 0;
  int checked = 0;
  int st[4], en[4], cur[4], v;
  int t, nchg;
  bit lfd[4];
  bit hi;
  always #2.5 ref_clk_in = ~ref_clk_in;
  analog_input_channel_formatter #(.ROUND_CYCLES(RC), .SEND_CYCLES(40)) analog_input_channel_formatter_i (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out), .conv_start_out(conv_start_out), .conv_valid_in(conv_valid_in),
    .conv_ch_in(conv_ch_in), .conv_current_in(conv_current_in), .field_comm_active_in(field_comm_active_in),
    .tx_valid_out(tx_valid_out), .tx_first_out(tx_first_out), .tx_data_out(tx_data_out),
    .tx_invalid_out(tx_invalid_out), .out_octets_out(out_octets_out));
  com_unit_model com_unit_model_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .tx_valid_in(tx_valid_out),
    .tx_first_in(tx_first_out), .tx_data_in(tx_data_out), .frame_out(frame), .frame_done_out(done));
  function automatic logic [5:0] ra(int ch, logic [2:0] ofs);
    return {1'b0, ch[1:0], ofs};
  endfunction : ra
  // expected channel word from points and loop current
  function automatic logic [15:0] word(int ch, int pv, int c);
    logic [15:0] p;
    p = (pv < 0) ? 16'h0000 : (pv > 65535) ? 16'hffff : pv[15:0];
    if (st[ch] >= 10000 && en[ch] <= 50000) return {p[15:4], 2'b00, lfd[ch] && (c < 1000 || c > 21000), c < 3600};
    return p;
  endfunction : word
  function automatic int raw(int ch, int c);
    return st[ch] + (c - 4000) * (en[ch] - st[ch]) / 16000;
  endfunction : raw
  function automatic int pct(int ch, int p);
    return st[ch] + p * (en[ch] - st[ch]) / 10000;
  endfunction : pct
  task automatic give_verdict;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(logic [5:0] a, logic [15:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(logic [5:0] a, logic [15:0] exp);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    check(rd_data_out, exp);
  endtask : rd
  task automatic conv(int ch, int c);
    @(posedge ref_clk_in);
    conv_ch_in <= ch[1:0];
    conv_current_in <= c[15:0];
    conv_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    conv_valid_in <= 1'b0;
  endtask : conv
  task automatic chw(int ch, logic [15:0] exp);
    check(hi ? {frame[16*ch +: 8], frame[16*ch+8 +: 8]} : frame[16*ch +: 16], exp);
  endtask : chw
  // two round starts, then two whole frames
  task automatic settle;
    int k;
    k = 0;
    repeat (2) begin
      @(posedge ref_clk_in);
      while (conv_start_out !== 1'b1 && k < 6 * RC) begin
        @(posedge ref_clk_in);
        k++;
      end
    end
    repeat (2) begin
      @(posedge ref_clk_in);
      while (done !== 1'b1 && k < 6 * RC) begin
        @(posedge ref_clk_in);
        k++;
      end
    end
    check(k >= 6 * RC, 16'h0);
  endtask : settle
  initial begin
    v = $urandom(32'hfcd0);
    for (int i = 0; i < 4; i++) begin
      st[i] = 10000;
      en[i] = 50000;
    end
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(ra(1, OFS_CFG), 16'h0010);
    rd(ra(2, OFS_OPEN_THR), 16'h03e8);
    rd(ra(3, OFS_SHORT_THR), 16'h5208);
    rd(6'h25, 16'h0000);
    repeat (3) begin
      hi = 1'($urandom_range(0, 1));
      wr(ADDR_CTRL, {14'h0, 1'($urandom_range(0, 1)), hi});
      for (int i = 0; i < 4; i++) begin
        lfd[i] = 1'($urandom_range(0, 1));
        cur[i] = $urandom_range(0, 12000) * 2;
        wr(ra(i, OFS_CFG), {11'h0, lfd[i], 4'h0});
        conv(i, cur[i]);
      end
      settle;
      for (int i = 0; i < 4; i++) chw(i, word(i, raw(i, cur[i]), cur[i]));
      check(tx_invalid_out, 4'h0);
    end
    wr(ra(0, OFS_SIM), 16'h4000);
    rd(ra(0, OFS_SIM), 16'h30d4);
    wr(ra(1, OFS_SIM), 16'hf63c);
    wr(ra(2, OFS_FALLBACK), 16'h1388);
    wr(ra(0, OFS_CFG), 16'h0013);
    wr(ra(1, OFS_CFG), 16'h0011);
    wr(ra(2, OFS_CFG), 16'h0014);
    wr(ra(3, OFS_CFG), 16'h0018);
    cur = '{21002, 3600, 500, 12000};
    lfd = '{1, 1, 1, 1};
    for (int i = 0; i < 4; i++) conv(i, cur[i]);
    settle;
    chw(0, word(0, pct(0, 12500), cur[0]));
    chw(1, word(1, pct(1, -2500), cur[1]));
    chw(2, word(2, pct(2, 5000), cur[2]));
    chw(3, word(3, raw(3, 12000), 12000));
    check(tx_invalid_out, 4'h5);
    wr(ra(2, OFS_CFG), 16'h0004);
    lfd[2] = 1'b0;
    conv(3, 23000);
    settle;
    chw(2, word(2, raw(2, 500), 500));
    chw(3, word(3, raw(3, 12000), 23000));
    check(tx_invalid_out, 4'h1);
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    hi = 1'b0;
    st[1] = 5000;
    en[2] = 65535;
    wr(ra(0, OFS_SCALE_START), 16'h0000);
    wr(ra(0, OFS_RATE), 16'h000a);
    wr(ra(1, OFS_SCALE_START), 16'h1388);
    wr(ra(2, OFS_SCALE_END), 16'hffff);
    cur[1] = $urandom_range(250, 1500) * 16;
    conv(0, 20000);
    conv(1, cur[1]);
    conv(2, 24000);
    settle;
    v = frame[15:0];
    check(v > 10000 && v < 50000 && (v - 10000) % 400 == 0, 16'h1);
    chw(1, word(1, raw(1, cur[1]), cur[1]));
    chw(2, 16'hffff);
    // field comm active: a new value may reach the stream on every third send cycle only
    field_comm_active_in <= 1'b1;
    wr(ra(0, OFS_CFG), 16'h0011);
    t = 0;
    nchg = 0;
    for (int j = 0; j < 8; j++) begin
      @(posedge ref_clk_in);
      while (done !== 1'b1 && t < 12 * RC) begin
        @(posedge ref_clk_in);
        t++;
      end
      if (j > 1 && frame[15:0] !== v[15:0]) nchg++;
      v = frame[15:0];
      wr(ra(0, OFS_SIM), 16'((j + 1) * 500));
    end
    check(16'(nchg), 16'h2);
    check(t >= 12 * RC, 16'h0);
    rd(ADDR_WORD_BASE + 6'h01, word(1, raw(1, cur[1]), cur[1]));
    rd(ADDR_STATUS, {3'h0, 1'b1, 4'h0, 1'b0, 1'b1, cur[1] > 21000, 1'b0, 4'h0});
    give_verdict;
  end
  initial begin
    #100000;
    n_fail++;
    give_verdict;
  end
endmodule : analog_input_channel_formatter_tb
bind analog_input_channel_formatter analog_input_channel_formatter_chk #(.ROUND_CYCLES(ROUND_CYCLES),
  .SEND_CYCLES(SEND_CYCLES)) chk_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
  .conv_start_out(conv_start_out), .tx_valid_out(tx_valid_out), .tx_first_out(tx_first_out),
  .tx_invalid_out(tx_invalid_out), .out_octets_out(out_octets_out));
`default_nettype wire
